// *** hdl/gdf_fault_bank.sv ***
// Purpose: fault status and first fault control registers of a gate driver
// Assumes: detector inputs are synchronous levels; enable pin synchronous
// Notes: registers reached over a 16-bit serial frame, read bit then 7-bit address
//
// How it works
// - supply status bits 7..4: drive uv, drive ov, regulator oc, pump uv.
// - supply status bit 3 motor uv, bit 2 motor ov, bits 1..0 zero.
// - clear command or long enable-low pulse clears every fault status register.
// - phase status bits 7..4 carry phase A drain and gate flags.
// - phase status bits 3..0 carry phase B drain and gate flags.
// - third status bits 7..4 phase C flags, bit 3 reads zero.
// - third status bits 2..0 flag sense channel one, two, three overcurrent.
// - status registers are read only and reset to zero.
// - control bits 7 and 6 make drive uv and ov report only.
// - control bit 5 makes regulator overcurrent report only.
// - control bits 4..2 make pump uv, motor uv, motor ov report only.
// - control bit 1 makes thermal shutdown report only.
// - warning report bit clear: warning shows only in its own flag.
// - warning report bit set: warning also drives fault pin and global flag.
// - first control register is read write and resets to zero.
// - global fault flag is the OR of all fault flags.
// - regulator summary flag ORs drive uv, drive ov, regulator oc.
// - clear command bit returns to zero by itself.
// - control register returns to reset value on sleep or shutdown.

`timescale 1ns/1ps
`default_nettype none

module gdf_fault_bank
#(
  parameter int SLEEP_CYCLES = gdf_pkg::SLEEP_CYCLES
)
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // serial register port
  input wire logic spi_sclk,
  input wire logic spi_cs_n,
  input wire logic spi_mosi,
  output logic spi_miso,
  output logic spi_miso_oe,
  // device mode
  input wire logic enable_pin,
  input wire logic shutdown_req,
  // analog detectors
  input wire gdf_pkg::gdf_fault_det_s fault_det,
  // fault reporting and protective action
  output logic fault_output_low,
  output logic global_fault_flag,
  output logic regulator_summary_flag,
  output gdf_pkg::gdf_protect_s protect
);

  logic [6:0] reg_addr;
  logic [7:0] reg_wdata;
  logic reg_wr;
  logic [7:0] reg_rdata;

  logic [7:0] supply, next_supply;
  logic [7:0] phase_ab, next_phase_ab;
  logic [7:0] phase_c, next_phase_c;
  logic thermal_warning_flag, next_thermal_warning_flag;
  logic thermal_shutdown_flag, next_thermal_shutdown_flag;
  logic [7:0] control_one, next_control_one;
  logic clear_faults_command, next_clear_faults_command;
  logic [gdf_pkg::SLEEP_CNT_W-1:0] low_cnt, next_low_cnt;
  logic sleep_active, next_sleep_active;
  logic next_fault_output_low, next_global, next_regulator;
  gdf_pkg::gdf_protect_s next_protect;
  logic clear_all, any_fault;

  // sticky update where a new event beats the clear
  function automatic logic [7:0] sticky(input logic [7:0] flags, input logic [7:0] ev,
                                        input logic [7:0] mask, input logic clr);
    sticky = clr ? (ev & mask) : ((flags | ev) & mask);
  endfunction

  function automatic logic wr_hit(input logic wr, input logic [6:0] a, input logic [6:0] ofs);
    wr_hit = wr && (a == ofs);
  endfunction

  // ---------------------------------------------------------------
  // serial slave
  // ---------------------------------------------------------------
  gdf_spi_slave gdf_spi_slave_inst
  (
    .clk_sys(clk_sys),
    .rst(rst),
    .spi_sclk(spi_sclk),
    .spi_cs_n(spi_cs_n),
    .spi_mosi(spi_mosi),
    .spi_miso(spi_miso),
    .spi_miso_oe(spi_miso_oe),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rdata(reg_rdata)
  );

  // ---------------------------------------------------------------
  // read mux
  // ---------------------------------------------------------------
  always_comb
  begin
    unique case (reg_addr)
      gdf_pkg::OFS_SUPPLY_STATUS: reg_rdata = supply;
      gdf_pkg::OFS_PHASE_AB_STATUS: reg_rdata = phase_ab;
      gdf_pkg::OFS_PHASE_C_STATUS: reg_rdata = phase_c;
      gdf_pkg::OFS_CONTROL_ONE: reg_rdata = control_one;
      // the clear bit always reads back as zero
      default: reg_rdata = 8'h00;
    endcase
  end

  // ---------------------------------------------------------------
  // sleep detect on enable pin
  // ---------------------------------------------------------------
  always_comb
  begin
    next_low_cnt = low_cnt;
    next_sleep_active = sleep_active;
    if (enable_pin)
    begin
      next_low_cnt = '0;
      next_sleep_active = 1'b0;
    end
    else if (low_cnt != SLEEP_CYCLES[gdf_pkg::SLEEP_CNT_W-1:0])
    begin
      next_low_cnt = low_cnt + 1'b1;
    end
    else
    begin
      // strictly longer than the sleep time
      next_sleep_active = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      low_cnt <= '0;
      sleep_active <= 1'b0;
    end
    else
    begin
      low_cnt <= next_low_cnt;
      sleep_active <= next_sleep_active;
    end
  end

  // ---------------------------------------------------------------
  // fault status and control registers
  // ---------------------------------------------------------------
  always_comb
  begin
    clear_all = clear_faults_command | sleep_active;
    next_supply = sticky(supply, fault_det.supply, gdf_pkg::MASK_SUPPLY, clear_all);
    next_phase_ab = sticky(phase_ab, fault_det.phase_ab, gdf_pkg::MASK_PHASE_AB, clear_all);
    next_phase_c = sticky(phase_c, fault_det.phase_c_sense, gdf_pkg::MASK_PHASE_C, clear_all);
    next_thermal_warning_flag = fault_det.thermal_warn | (thermal_warning_flag & ~clear_all);
    next_thermal_shutdown_flag = fault_det.thermal_sd | (thermal_shutdown_flag & ~clear_all);
    next_control_one = control_one;
    if (wr_hit(reg_wr, reg_addr, gdf_pkg::OFS_CONTROL_ONE))
    begin
      next_control_one = reg_wdata;
    end
    if (sleep_active || shutdown_req)
    begin
      next_control_one = gdf_pkg::RST_CONTROL_ONE;
    end
    next_clear_faults_command = wr_hit(reg_wr, reg_addr, gdf_pkg::OFS_IC_CONTROL) &&
                                reg_wdata[gdf_pkg::BIT_CLEAR_FAULTS];
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      supply <= gdf_pkg::RST_STATUS;
      phase_ab <= gdf_pkg::RST_STATUS;
      phase_c <= gdf_pkg::RST_STATUS;
      thermal_warning_flag <= 1'b0;
      thermal_shutdown_flag <= 1'b0;
      control_one <= gdf_pkg::RST_CONTROL_ONE;
      clear_faults_command <= 1'b0;
    end
    else
    begin
      supply <= next_supply;
      phase_ab <= next_phase_ab;
      phase_c <= next_phase_c;
      thermal_warning_flag <= next_thermal_warning_flag;
      thermal_shutdown_flag <= next_thermal_shutdown_flag;
      control_one <= next_control_one;
      clear_faults_command <= next_clear_faults_command;
    end
  end

  // ---------------------------------------------------------------
  // reporting and protection outputs
  // ---------------------------------------------------------------
  always_comb
  begin
    // warning joins the report only when selected
    any_fault = (|supply) | (|phase_ab) | (|phase_c) | thermal_shutdown_flag |
                (thermal_warning_flag & control_one[gdf_pkg::BIT_WARN_REPORT]);
    next_global = any_fault;
    next_fault_output_low = ~any_fault;
    next_regulator = |(supply & gdf_pkg::MASK_REGULATOR);
    // live conditions gated by report-only bits
    next_protect.drive_uv = fault_det.supply[gdf_pkg::BIT_DRIVE_UV] &
                            ~control_one[gdf_pkg::BIT_DRIVE_UV];
    next_protect.drive_ov = fault_det.supply[gdf_pkg::BIT_DRIVE_OV] &
                            ~control_one[gdf_pkg::BIT_DRIVE_OV];
    next_protect.reg_oc = fault_det.supply[gdf_pkg::BIT_REG_OC] &
                          ~control_one[gdf_pkg::BIT_REG_OC];
    next_protect.cp_uv = fault_det.supply[gdf_pkg::BIT_CP_UV] &
                         ~control_one[gdf_pkg::BIT_CP_UV];
    next_protect.motor_uv = fault_det.supply[gdf_pkg::BIT_MOTOR_UV] &
                            ~control_one[gdf_pkg::BIT_MOTOR_UV];
    next_protect.motor_ov = fault_det.supply[gdf_pkg::BIT_MOTOR_OV] &
                            ~control_one[gdf_pkg::BIT_MOTOR_OV];
    next_protect.thermal_sd = fault_det.thermal_sd &
                              ~control_one[gdf_pkg::BIT_THERMAL_SD_RO];
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      global_fault_flag <= 1'b0;
      fault_output_low <= 1'b1;
      regulator_summary_flag <= 1'b0;
      protect <= '0;
    end
    else
    begin
      global_fault_flag <= next_global;
      fault_output_low <= next_fault_output_low;
      regulator_summary_flag <= next_regulator;
      protect <= next_protect;
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  property p_unassigned_zero;
    @(posedge clk_sys) disable iff (rst)
    supply[1:0] == 2'b00 && phase_c[3] == 1'b0;
  endproperty
  a_unassigned_zero: assert property (p_unassigned_zero)
    else $error("unassigned status bit set");

  property p_clear_cmd;
    @(posedge clk_sys) disable iff (rst)
    clear_faults_command |=> supply == ($past(fault_det.supply) & 8'hfc) &&
                             phase_ab == $past(fault_det.phase_ab);
  endproperty
  a_clear_cmd: assert property (p_clear_cmd)
    else $error("clear command did not clear status");

  property p_self_clear;
    @(posedge clk_sys) disable iff (rst)
    clear_faults_command |=> !clear_faults_command;
  endproperty
  a_self_clear: assert property (p_self_clear)
    else $error("clear command bit did not return to zero");

  property p_sticky;
    @(posedge clk_sys) disable iff (rst)
    (phase_c[7] && !clear_faults_command && !sleep_active) |=> phase_c[7];
  endproperty
  a_sticky: assert property (p_sticky)
    else $error("fault flag dropped without a clear");

  property p_sleep_ctrl;
    @(posedge clk_sys) disable iff (rst)
    (sleep_active || shutdown_req) |=> control_one == 8'h00;
  endproperty
  a_sleep_ctrl: assert property (p_sleep_ctrl)
    else $error("control register kept value in sleep");

  property p_ctrl_write;
    @(posedge clk_sys) disable iff (rst)
    (reg_wr && reg_addr == 7'h04 && !sleep_active && !shutdown_req) |=>
      control_one == $past(reg_wdata);
  endproperty
  a_ctrl_write: assert property (p_ctrl_write)
    else $error("control write not stored");

  property p_ro_write;
    @(posedge clk_sys) disable iff (rst)
    (reg_wr && reg_addr == 7'h01 && fault_det.supply == 8'h00 && !clear_all) |=>
      $stable(supply);
  endproperty
  a_ro_write: assert property (p_ro_write)
    else $error("write changed a status register");

  property p_regulator;
    @(posedge clk_sys) disable iff (rst)
    ##1 regulator_summary_flag == ($past(supply[7]) | $past(supply[6]) | $past(supply[5]));
  endproperty
  a_regulator: assert property (p_regulator)
    else $error("regulator summary mismatch");

  property p_pin_follows_global;
    @(posedge clk_sys) disable iff (rst)
    ##1 global_fault_flag == ((|$past(supply)) | (|$past(phase_ab)) | (|$past(phase_c)) |
      $past(thermal_shutdown_flag) | ($past(thermal_warning_flag) & $past(control_one[0])))
      && fault_output_low == !global_fault_flag;
  endproperty
  a_pin_follows_global: assert property (p_pin_follows_global)
    else $error("fault pin and global flag disagree");

  property p_warn_report;
    @(posedge clk_sys) disable iff (rst)
    (thermal_warning_flag && control_one[0]) |=> !fault_output_low;
  endproperty
  a_warn_report: assert property (p_warn_report)
    else $error("reported warning did not drive fault pin");

  property p_drive_uv_only;
    @(posedge clk_sys) disable iff (rst)
    ##1 protect.drive_uv == ($past(fault_det.supply[7]) && !$past(control_one[7]));
  endproperty
  a_drive_uv_only: assert property (p_drive_uv_only)
    else $error("drive undervoltage action wrong");

  property p_thermal_sd_only;
    @(posedge clk_sys) disable iff (rst)
    control_one[1] |=> !protect.thermal_sd;
  endproperty
  a_thermal_sd_only: assert property (p_thermal_sd_only)
    else $error("thermal shutdown acted in report-only mode");

endmodule // gdf_fault_bank

`default_nettype wire

// *** hdl/gdf_pkg.sv ***
// Purpose: shared constants and carriers for the gate driver fault register bank
// Assumes: 125 MHz system clock, 8-bit registers behind a 16-bit serial frame
// Notes: every offset, field position, reset value and timing count lives here

package gdf_pkg;

  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [6:0] OFS_SUPPLY_STATUS = 7'h01;
  localparam logic [6:0] OFS_PHASE_AB_STATUS = 7'h02;
  localparam logic [6:0] OFS_PHASE_C_STATUS = 7'h03;
  localparam logic [6:0] OFS_CONTROL_ONE = 7'h04;
  localparam logic [6:0] OFS_IC_CONTROL = 7'h06;

  // ---------------------------------------------------------------
  // reset values and valid bit masks
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_STATUS = 8'h00;
  localparam logic [7:0] RST_CONTROL_ONE = 8'h00;
  localparam logic [7:0] MASK_SUPPLY = 8'hfc;
  localparam logic [7:0] MASK_PHASE_AB = 8'hff;
  localparam logic [7:0] MASK_PHASE_C = 8'hf7;
  localparam logic [7:0] MASK_REGULATOR = 8'he0;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int BIT_DRIVE_UV = 7;
  localparam int BIT_DRIVE_OV = 6;
  localparam int BIT_REG_OC = 5;
  localparam int BIT_CP_UV = 4;
  localparam int BIT_MOTOR_UV = 3;
  localparam int BIT_MOTOR_OV = 2;
  localparam int BIT_THERMAL_SD_RO = 1;
  localparam int BIT_WARN_REPORT = 0;
  localparam int BIT_CLEAR_FAULTS = 7;

  // ---------------------------------------------------------------
  // serial frame layout
  // ---------------------------------------------------------------
  localparam logic [4:0] FRAME_BITS = 5'h10;
  localparam logic [4:0] HEADER_BITS = 5'h08;
  localparam int BIT_FRAME_READ = 15;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 8;
  localparam int SLEEP_TIME_NS = 850000;
  localparam int SLEEP_CYCLES = (SLEEP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SLEEP_CNT_W = 17;

  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [7:0] supply;
    logic [7:0] phase_ab;
    logic [7:0] phase_c_sense;
    logic thermal_warn;
    logic thermal_sd;
  } gdf_fault_det_s;

  typedef struct packed {
    logic drive_uv;
    logic drive_ov;
    logic reg_oc;
    logic cp_uv;
    logic motor_uv;
    logic motor_ov;
    logic thermal_sd;
  } gdf_protect_s;

endpackage

// *** hdl/gdf_spi_slave.sv ***
// Purpose: serial slave framing, mode 0, 16-bit frames
// Assumes: sclk, cs_n and mosi already synchronous to clk_sys and slower than clk/4
// Notes: a frame shorter than 16 bits is dropped when chip select rises; bits past the sixteenth are ignored

`timescale 1ns/1ps
`default_nettype none

module gdf_spi_slave
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // serial pins
  input wire logic spi_sclk,
  input wire logic spi_cs_n,
  input wire logic spi_mosi,
  output logic spi_miso,
  output logic spi_miso_oe,
  // register side
  output logic [6:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_wr,
  input wire logic [7:0] reg_rdata
);

  logic sclk_q, next_sclk_q;
  logic cs_q, next_cs_q;
  logic [4:0] bit_cnt, next_bit_cnt;
  logic [15:0] shin, next_shin;
  logic [7:0] txsh, next_txsh;
  logic next_oe, next_wr;
  logic [6:0] next_addr;
  logic [7:0] next_wdata;
  logic rise, fall;

  // ---------------------------------------------------------------
  // frame shifter
  // ---------------------------------------------------------------
  always_comb
  begin
    rise = spi_sclk & ~sclk_q;
    fall = ~spi_sclk & sclk_q;
    next_sclk_q = spi_sclk;
    next_cs_q = spi_cs_n;
    next_bit_cnt = bit_cnt;
    next_shin = shin;
    next_txsh = txsh;
    next_addr = reg_addr;
    next_wdata = reg_wdata;
    next_wr = 1'b0;
    next_oe = ~spi_cs_n;
    if (spi_cs_n)
    begin
      next_bit_cnt = 5'h00;
      // commit only a complete write frame
      if (!cs_q && bit_cnt == gdf_pkg::FRAME_BITS && !shin[gdf_pkg::BIT_FRAME_READ])
      begin
        next_wr = 1'b1;
        next_wdata = shin[7:0];
      end
    end
    else
    begin
      if (rise && bit_cnt != gdf_pkg::FRAME_BITS)
      begin
        next_shin = {shin[14:0], spi_mosi};
        next_bit_cnt = bit_cnt + 5'h01;
        if (bit_cnt == gdf_pkg::HEADER_BITS - 5'h01)
        begin
          next_addr = {shin[5:0], spi_mosi};
        end
      end
      // read data must be on the wire before the ninth rising edge
      if (fall && bit_cnt == gdf_pkg::HEADER_BITS)
      begin
        next_txsh = reg_rdata;
      end
      else if (fall && bit_cnt > gdf_pkg::HEADER_BITS)
      begin
        next_txsh = {txsh[6:0], 1'b0};
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      sclk_q <= 1'b0;
      cs_q <= 1'b1;
      bit_cnt <= 5'h00;
      shin <= 16'h0000;
      txsh <= 8'h00;
      reg_addr <= 7'h00;
      reg_wdata <= 8'h00;
      reg_wr <= 1'b0;
      spi_miso_oe <= 1'b0;
    end
    else
    begin
      sclk_q <= next_sclk_q;
      cs_q <= next_cs_q;
      bit_cnt <= next_bit_cnt;
      shin <= next_shin;
      txsh <= next_txsh;
      reg_addr <= next_addr;
      reg_wdata <= next_wdata;
      reg_wr <= next_wr;
      spi_miso_oe <= next_oe;
    end
  end

  assign spi_miso = txsh[7];

endmodule // gdf_spi_slave

`default_nettype wire

// *** verification/gdf_spi_host.sv ***
// Purpose: serial master model of the on-package controller
// Assumes: mode 0 frames: read bit, 7-bit address, 8 data bits, MSB first
// Notes: sclk half period is four system clocks, twice the slave minimum

`timescale 1ns/1ps
`default_nettype none

module gdf_spi_host
(
  // clock
  input wire logic clk_sys,
  // serial pins
  output logic spi_sclk,
  output logic spi_cs_n,
  output logic spi_mosi,
  input wire logic spi_miso,
  input wire logic spi_miso_oe
);
  // ---------------------------------------------------------------
  // frame engine
  // ---------------------------------------------------------------
  initial
  begin
    spi_sclk = 1'b0;
    spi_cs_n = 1'b1;
    spi_mosi = 1'b0;
  end

  task automatic frame(input logic [15:0] tx, output logic [7:0] rx);
    rx = 8'h00;
    @(negedge clk_sys);
    spi_cs_n = 1'b0;
    for (int i = 15; i >= 0; i--)
    begin
      spi_mosi = tx[i];
      repeat (4) @(negedge clk_sys);
      spi_sclk = 1'b1;
      // an undriven miso must never pass for data
      if (i < 8)
        rx[i] = spi_miso_oe ? spi_miso : 1'bx;
      repeat (4) @(negedge clk_sys);
      spi_sclk = 1'b0;
    end
    repeat (4) @(negedge clk_sys);
    spi_cs_n = 1'b1;
    // idle data line flips so nothing leans on a stale level
    spi_mosi = ~spi_mosi;
    repeat (3) @(negedge clk_sys);
  endtask

  task automatic write_reg(input logic [6:0] addr, input logic [7:0] data);
    logic [7:0] unused;
    frame({1'b0, addr, data}, unused);
  endtask

  task automatic read_reg(input logic [6:0] addr, output logic [7:0] data);
    frame({1'b1, addr, 8'h00}, data);
  endtask

  task automatic clear_faults();
    write_reg(gdf_pkg::OFS_IC_CONTROL, 8'h80);
  endtask
endmodule // gdf_spi_host

`default_nettype wire

// *** verification/test_gdf_fault_bank.sv ***
// Purpose: self-checking bench for the gate driver fault register bank
// Assumes: serial master model drives the register port
// Notes: sleep count shortened to 20 clocks to keep the run short

`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, ex, got) \
  begin \
    checked++; \
    if ((got) !== (ex)) \
    begin \
      num_errors++; \
      $display("ERROR %s expected %h seen %h", nm, ex, got); \
    end \
  end

module test_gdf_fault_bank;
  localparam int SLP = 20;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic spi_sclk, spi_cs_n, spi_mosi, spi_miso, spi_miso_oe;
  logic enable_pin = 1'b1;
  logic shutdown_req = 1'b0;
  gdf_pkg::gdf_fault_det_s fault_det = '0;
  logic fault_output_low, global_fault_flag, regulator_summary_flag;
  gdf_pkg::gdf_protect_s protect;
  logic [7:0] rd;
  int num_errors = 0;
  int checked = 0;
  int cycles = 0;

  always #4 clk_sys = ~clk_sys;

  gdf_fault_bank #(.SLEEP_CYCLES(SLP)) gdf_fault_bank_inst (.clk_sys(clk_sys), .rst(rst),
    .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi), .spi_miso(spi_miso),
    .spi_miso_oe(spi_miso_oe), .enable_pin(enable_pin), .shutdown_req(shutdown_req),
    .fault_det(fault_det), .fault_output_low(fault_output_low),
    .global_fault_flag(global_fault_flag),
    .regulator_summary_flag(regulator_summary_flag), .protect(protect));

  gdf_spi_host gdf_spi_host_inst (.clk_sys(clk_sys), .spi_sclk(spi_sclk),
    .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi), .spi_miso(spi_miso),
    .spi_miso_oe(spi_miso_oe));

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic wait_clk(input int n);
    repeat (n) @(negedge clk_sys);
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    gdf_spi_host_inst.write_reg(a, d);
  endtask

  task automatic rd_reg(input logic [6:0] a, output logic [7:0] d);
    gdf_spi_host_inst.read_reg(a, d);
  endtask

  task automatic clear();
    gdf_spi_host_inst.clear_faults();
    wait_clk(2);
  endtask

  task automatic test_done();
    $display("checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // hang guard: a stuck run counts as a mismatch
  always @(posedge clk_sys)
  begin
    cycles <= cycles + 1;
    if (cycles == 60000)
    begin
      num_errors = num_errors + 1;
      test_done();
    end
  end

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic test_reset();
    for (int a = 1; a < 5; a++)
    begin
      rd_reg(7'(a), rd);
      `CHK("reset value", 8'h00, rd)
    end
    `CHK("pin after reset", 1'b1, fault_output_low)
    $display("test_reset done");
  endtask

  task automatic test_status_bits();
    logic [7:0] v, m;
    logic [6:0] a;
    for (int r = 0; r < 3; r++)
    begin
      for (int b = 0; b < 8; b++)
      begin
        v = 8'h01 << b;
        m = (r == 0) ? gdf_pkg::MASK_SUPPLY : (r == 1) ? gdf_pkg::MASK_PHASE_AB :
          gdf_pkg::MASK_PHASE_C;
        a = gdf_pkg::OFS_SUPPLY_STATUS + 7'(r);
        fault_det.supply = (r == 0) ? v : 8'h00;
        fault_det.phase_ab = (r == 1) ? v : 8'h00;
        fault_det.phase_c_sense = (r == 2) ? v : 8'h00;
        wait_clk(1);
        fault_det = '0;
        wait_clk(2);
        rd_reg(a, rd);
        `CHK("status", v & m, rd)
        `CHK("global", |(v & m), global_fault_flag)
        `CHK("fault pin", ~|(v & m), fault_output_low)
        `CHK("summary", (r == 0) && (b > 4), regulator_summary_flag)
        clear();
        rd_reg(a, rd);
        `CHK("cleared", 8'h00, rd)
        `CHK("global cleared", 1'b0, global_fault_flag)
      end
    end
    rd_reg(gdf_pkg::OFS_IC_CONTROL, rd);
    `CHK("clear command", 8'h00, rd)
    $display("test_status_bits done");
  endtask

  task automatic test_read_only();
    fault_det.supply = 8'h80;
    wait_clk(1);
    fault_det = '0;
    for (int a = 1; a < 4; a++)
      wr(7'(a), 8'hff);
    wr(7'h10, 8'h5a);
    rd_reg(gdf_pkg::OFS_SUPPLY_STATUS, rd);
    `CHK("ro supply", 8'h80, rd)
    rd_reg(gdf_pkg::OFS_PHASE_AB_STATUS, rd);
    `CHK("ro phase", 8'h00, rd)
    rd_reg(7'h10, rd);
    `CHK("unmapped", 8'h00, rd)
    clear();
    $display("test_read_only done");
  endtask

  task automatic test_control();
    logic [7:0] c;
    wr(gdf_pkg::OFS_CONTROL_ONE, 8'ha5);
    rd_reg(gdf_pkg::OFS_CONTROL_ONE, rd);
    `CHK("control rw", 8'ha5, rd)
    fault_det.supply = 8'hfc;
    fault_det.thermal_sd = 1'b1;
    for (int k = 0; k < 8; k++)
    begin
      c = (k == 0) ? 8'h00 : (8'h01 << k);
      wr(gdf_pkg::OFS_CONTROL_ONE, c);
      wait_clk(3);
      `CHK("protect", ~c[7:1], protect)
    end
    rd_reg(gdf_pkg::OFS_SUPPLY_STATUS, rd);
    `CHK("still reported", 8'hfc, rd)
    fault_det = '0;
    wr(gdf_pkg::OFS_CONTROL_ONE, 8'h00);
    clear();
    $display("test_control done");
  endtask

  task automatic test_warning();
    for (int k = 0; k < 2; k++)
    begin
      wr(gdf_pkg::OFS_CONTROL_ONE, 8'(k));
      fault_det.thermal_warn = 1'b1;
      wait_clk(1);
      fault_det = '0;
      wait_clk(2);
      `CHK("warn global", k == 1, global_fault_flag)
      `CHK("warn pin", k == 0, fault_output_low)
      clear();
    end
    wr(gdf_pkg::OFS_CONTROL_ONE, 8'h00);
    $display("test_warning done");
  endtask

  task automatic test_sleep();
    wr(gdf_pkg::OFS_CONTROL_ONE, 8'h5a);
    fault_det.supply = 8'h40;
    wait_clk(1);
    fault_det = '0;
    // a short low pulse must not count as sleep
    enable_pin = 1'b0;
    wait_clk(SLP - 2);
    enable_pin = 1'b1;
    wait_clk(2);
    rd_reg(gdf_pkg::OFS_SUPPLY_STATUS, rd);
    `CHK("short pulse", 8'h40, rd)
    enable_pin = 1'b0;
    wait_clk(SLP + 4);
    enable_pin = 1'b1;
    wait_clk(2);
    rd_reg(gdf_pkg::OFS_SUPPLY_STATUS, rd);
    `CHK("sleep clear", 8'h00, rd)
    rd_reg(gdf_pkg::OFS_CONTROL_ONE, rd);
    `CHK("sleep control", 8'h00, rd)
    wr(gdf_pkg::OFS_CONTROL_ONE, 8'h33);
    shutdown_req = 1'b1;
    wait_clk(3);
    shutdown_req = 1'b0;
    wait_clk(2);
    rd_reg(gdf_pkg::OFS_CONTROL_ONE, rd);
    `CHK("shutdown control", 8'h00, rd)
    $display("test_sleep done");
  endtask

  initial
  begin
    repeat (20) @(negedge clk_sys);
    rst = 1'b0;
    wait_clk(2);
    test_reset();
    test_status_bits();
    test_read_only();
    test_control();
    test_warning();
    test_sleep();
    test_done();
  end
endmodule // test_gdf_fault_bank

`default_nettype wire
